// ===== inc/clm_pkg.sv
// Purpose: constants and types of the configurable logic macrocell
// Assumes: word-addressed register port, 32-bit data
// Notes:   term masks hold 72 literals, true inputs low, complements high

package clm_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned N_SIG    = 36;
   localparam int unsigned LIT_W    = 72;
   localparam int unsigned HI_W     = 8;
   localparam int unsigned N_PAL    = 4;
   localparam int unsigned N_PLA    = 32;
   localparam int unsigned N_CT     = 8;
   localparam int unsigned N_TERMS  = 44;
   localparam int unsigned PLA_BASE = 4;
   localparam int unsigned CT_BASE  = 36;
   localparam int unsigned IDX_W    = 6;

   // control term slots inside a logic block
   localparam int unsigned CT_SR_A  = 0;
   localparam int unsigned CT_SR_B  = 1;
   localparam int unsigned CT_OE_A  = 2;
   localparam int unsigned CT_CLK_A = 6;
   localparam int unsigned CT_CLK_B = 7;

   // ------------------------------------------------------------------
   // register map (word addresses)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] TERM_LIMIT   = 8'hb0;
   localparam logic [ADDR_W-1:0] ADDR_CFG     = 8'hc0;
   localparam logic [ADDR_W-1:0] ADDR_PLA_SEL = 8'hc1;
   localparam logic [ADDR_W-1:0] ADDR_CT_KIND = 8'hc2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'hc3;
   localparam logic [1:0]        WORD_LO      = 2'h0;
   localparam logic [1:0]        WORD_MID     = 2'h1;
   localparam logic [1:0]        WORD_HI      = 2'h2;

   // configuration word fields
   localparam int unsigned CFG_MODE_LSB  = 0;
   localparam int unsigned CFG_CLK_LSB   = 2;
   localparam int unsigned CFG_FALL      = 4;
   localparam int unsigned CFG_AR_EN     = 5;
   localparam int unsigned CFG_AR_PRESET = 6;
   localparam int unsigned CFG_AR_SEL    = 7;
   localparam int unsigned CFG_OE_LSB    = 8;
   localparam int unsigned CFG_XOR       = 11;
   localparam int unsigned CFG_INV       = 12;
   localparam int unsigned CFG_PIN       = 13;
   localparam int unsigned CFG_PIN_IN    = 14;
   localparam int unsigned CFG_USED_W    = 15;

   // status word fields
   localparam int unsigned ST_REG      = 0;
   localparam int unsigned ST_MC       = 1;
   localparam int unsigned ST_PIN_FB   = 2;
   localparam int unsigned ST_OE       = 3;
   localparam int unsigned ST_PULLDOWN = 4;
   localparam int unsigned ST_CT_LSB   = 5;
   localparam int unsigned ST_GR       = 13;

   // reset values
   localparam logic [CFG_USED_W-1:0] CFG_RESET     = 15'h0500;
   localparam logic [N_PLA-1:0]      PLA_SEL_RESET = 32'h0000_0000;
   localparam logic [N_CT-1:0]       CT_KIND_RESET = 8'h00;
   localparam logic [4:0]            SYNC_RESET    = 5'h04;

   // synchroniser slots
   localparam int unsigned SY_GCLK_A = 0;
   localparam int unsigned SY_GCLK_B = 1;
   localparam int unsigned SY_GR_N   = 2;
   localparam int unsigned SY_GTS    = 3;
   localparam int unsigned SY_PIN    = 4;

   typedef enum logic [1:0] {
      MODE_COMB = 2'b00,
      MODE_D    = 2'b01,
      MODE_T    = 2'b10
   } clm_mode_e;

   typedef enum logic [1:0] {
      CLK_GLOBAL_A = 2'b00,
      CLK_GLOBAL_B = 2'b01,
      CLK_ASYNC_A  = 2'b10,
      CLK_ASYNC_B  = 2'b11
   } clm_clk_sel_e;

   typedef enum logic [2:0] {
      OE_TERM_A     = 3'b000,
      OE_TERM_B     = 3'b001,
      OE_TERM_C     = 3'b010,
      OE_TERM_D     = 3'b011,
      OE_ALWAYS_ON  = 3'b100,
      OE_ALWAYS_OFF = 3'b101
   } clm_oe_sel_e;

endpackage

// ===== core/clm_macrocell.sv
// Purpose: one macrocell of a logic block with its term arrays
// Assumes: clk far faster than the global clocks it samples
// Notes:   global clock edges are seen after a two-flop synchroniser

`timescale 1ns/100ps

// Summary of operation
// - D, T register or combinational bypass
// - register clock from one of four sources
// - two sources from externally driven global clocks
// - global clocks usable on either edge
// - two sources are internal async clock terms
// - set/reset terms drive async preset or reset
// - preset or reset, never both together
// - preset/reset individually disableable
// - power-on reset leaves register at zero
// - global reset works regardless of term enable
// - low global reset clears every register
// - output enable chosen from four terms
// - output buffer may be always on/off
// - global tristate high disables all outputs
// - pin macrocell: macrocell and pin feedback
// - input pin: buffer off, pin value fed back
// - buried macrocell: single feedback path
// - buried-only pin gets pull-down
// - OR or XOR of PAL, PLA, either polarity
// - four PAL terms, thirty-two shared PLA terms
module clm_macrocell
   import clm_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wr_data,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rd_data,
   // global pins
   input  wire logic              global_clock_a,
   input  wire logic              global_clock_b,
   input  wire logic              global_reset_n,
   input  wire logic              global_tristate,
   // logic block inputs
   input  wire logic [N_SIG-1:0]  local_interconnect_in,
   // i/o pin
   input  wire logic              pin_in,
   output logic                   pin_out,
   output logic                   pin_oe,
   output logic                   pin_pulldown,
   // feedback to local interconnect
   output logic                   macrocell_feedback,
   output logic                   pin_feedback
);

   // ------------------------------------------------------------------
   // term evaluation
   // ------------------------------------------------------------------
   // an empty product is false so unprogrammed terms stay quiet
   function automatic logic term_eval(
      input logic [LIT_W-1:0] mask,
      input logic [N_SIG-1:0] sig,
      input logic             is_sum
   );
      logic [LIT_W-1:0] lits;
      lits = {~sig, sig};
      if (is_sum)
         return |(mask & lits);
      return (|mask) && (&(lits | ~mask));
   endfunction

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [LIT_W-1:0]      term_mask_reg [N_TERMS];
   logic [N_TERMS-1:0]    term_we;
   logic [N_TERMS-1:0]    term_val;
   logic [CFG_USED_W-1:0] cfg_reg;
   logic [N_PLA-1:0]      pla_sel_reg;
   logic [N_CT-1:0]       ct_kind_reg;
   logic [4:0]            sync_meta_reg;
   logic [4:0]            sync_reg;
   logic [1:0]            gclk_prev_reg;
   logic [1:0]            aclk_prev_reg;
   logic                  mc_reg;
   logic                  mc_next;
   logic [DATA_W-1:0]     rd_data_reg;
   logic [DATA_W-1:0]     rd_next;
   logic                  pin_out_reg;
   logic                  pin_oe_reg;
   logic                  pulldown_reg;
   logic                  mc_fb_reg;
   logic                  pin_fb_reg;
   logic                  clk_edge;
   logic                  oe_cfg;

   // ------------------------------------------------------------------
   // synchronisers for pins
   // ------------------------------------------------------------------
   wire [4:0] pins_raw = {pin_in, global_tristate, global_reset_n,
                          global_clock_b, global_clock_a};

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sync_meta_reg <= SYNC_RESET;
         sync_reg      <= SYNC_RESET;
      end
      else
      begin
         sync_meta_reg <= pins_raw;
         sync_reg      <= sync_meta_reg;
      end
   end

   wire gclk_a    = sync_reg[SY_GCLK_A];
   wire gclk_b    = sync_reg[SY_GCLK_B];
   wire gr_active = ~sync_reg[SY_GR_N];
   wire gts_sync  = sync_reg[SY_GTS];
   wire pin_sync  = sync_reg[SY_PIN];

   // ------------------------------------------------------------------
   // term arrays and their storage
   // ------------------------------------------------------------------
   wire [1:0]       word_sel  = reg_addr[1:0];
   wire [IDX_W-1:0] term_idx  = reg_addr[ADDR_W-1:2];
   wire             term_addr = reg_addr < TERM_LIMIT;

   for (genvar t = 0; t < N_TERMS; t++)
   begin : g_term
      assign term_we[t] = reg_wr && term_addr && (term_idx == IDX_W'(t));

      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
            term_mask_reg[t] <= '0;
         else if (term_we[t] && word_sel == WORD_LO)
            term_mask_reg[t][31:0] <= reg_wr_data;
         else if (term_we[t] && word_sel == WORD_MID)
            term_mask_reg[t][63:32] <= reg_wr_data;
         else if (term_we[t] && word_sel == WORD_HI)
            term_mask_reg[t][LIT_W-1:64] <= reg_wr_data[HI_W-1:0];
      end

      if (t >= CT_BASE)
      begin : g_ct
         // control terms pick product or sum per slot
         assign term_val[t] = term_eval(term_mask_reg[t],
            local_interconnect_in, ct_kind_reg[t-CT_BASE]);
      end
      else
      begin : g_pt
         assign term_val[t] = term_eval(term_mask_reg[t],
            local_interconnect_in, 1'b0);
      end
   end

   wire [N_CT-1:0] ct_val = term_val[N_TERMS-1:CT_BASE];

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cfg_reg     <= CFG_RESET;
         pla_sel_reg <= PLA_SEL_RESET;
         ct_kind_reg <= CT_KIND_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_CFG)
            cfg_reg <= reg_wr_data[CFG_USED_W-1:0];
         if (reg_addr == ADDR_PLA_SEL)
            pla_sel_reg <= reg_wr_data;
         if (reg_addr == ADDR_CT_KIND)
            ct_kind_reg <= reg_wr_data[N_CT-1:0];
      end
   end

   wire clm_mode_e    mode    = clm_mode_e'(cfg_reg[CFG_MODE_LSB +: 2]);
   wire clm_clk_sel_e clk_sel = clm_clk_sel_e'(cfg_reg[CFG_CLK_LSB +: 2]);
   wire clm_oe_sel_e  oe_sel  = clm_oe_sel_e'(cfg_reg[CFG_OE_LSB +: 3]);
   wire falling    = cfg_reg[CFG_FALL];
   wire ar_en      = cfg_reg[CFG_AR_EN];
   wire ar_preset  = cfg_reg[CFG_AR_PRESET];
   wire ar_sel     = cfg_reg[CFG_AR_SEL];
   wire use_xor    = cfg_reg[CFG_XOR];
   wire invert     = cfg_reg[CFG_INV];
   wire has_pin    = cfg_reg[CFG_PIN];
   wire pin_is_in  = cfg_reg[CFG_PIN_IN];

   // ------------------------------------------------------------------
   // logic input
   // ------------------------------------------------------------------
   wire pal_sum  = |term_val[N_PAL-1:0];
   wire pla_sum  = |(term_val[CT_BASE-1:PLA_BASE] & pla_sel_reg);
   wire combined = use_xor ? (pal_sum ^ pla_sum) : (pal_sum | pla_sum);
   wire logic_in = combined ^ invert;

   // ------------------------------------------------------------------
   // clock source selection
   // ------------------------------------------------------------------
   wire rise_a  = gclk_a & ~gclk_prev_reg[0];
   wire fall_a  = ~gclk_a & gclk_prev_reg[0];
   wire rise_b  = gclk_b & ~gclk_prev_reg[1];
   wire fall_b  = ~gclk_b & gclk_prev_reg[1];
   wire arise_a = ct_val[CT_CLK_A] & ~aclk_prev_reg[0];
   wire arise_b = ct_val[CT_CLK_B] & ~aclk_prev_reg[1];

   always_comb
   begin
      case (clk_sel)
         CLK_GLOBAL_A: clk_edge = falling ? fall_a : rise_a;
         CLK_GLOBAL_B: clk_edge = falling ? fall_b : rise_b;
         CLK_ASYNC_A:  clk_edge = arise_a;
         CLK_ASYNC_B:  clk_edge = arise_b;
         default:      clk_edge = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // macrocell register
   // ------------------------------------------------------------------
   // one select bit means preset and reset cannot both be active
   wire sr_term   = ar_sel ? ct_val[CT_SR_B] : ct_val[CT_SR_A];
   wire ar_active = ar_en & sr_term;
   wire force_on  = gr_active | ar_active;
   // global reset ignores the term enable and wins over a preset
   wire force_val = gr_active ? 1'b0 : ar_preset;
   wire reg_value = force_on ? force_val : mc_reg;
   wire mc_out    = (mode == MODE_COMB) ? logic_in : reg_value;

   always_comb
   begin
      mc_next = mc_reg;
      if (force_on)
         mc_next = force_val;
      else if (clk_edge && mode == MODE_D)
         mc_next = logic_in;
      else if (clk_edge && mode == MODE_T)
         mc_next = mc_reg ^ logic_in;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         mc_reg        <= 1'b0;
         gclk_prev_reg <= 2'b00;
         aclk_prev_reg <= 2'b00;
      end
      else
      begin
         mc_reg        <= mc_next;
         gclk_prev_reg <= {gclk_b, gclk_a};
         aclk_prev_reg <= {ct_val[CT_CLK_B], ct_val[CT_CLK_A]};
      end
   end

   // ------------------------------------------------------------------
   // output buffer and feedback
   // ------------------------------------------------------------------
   always_comb
   begin
      case (oe_sel)
         OE_TERM_A:     oe_cfg = ct_val[CT_OE_A];
         OE_TERM_B:     oe_cfg = ct_val[CT_OE_A+1];
         OE_TERM_C:     oe_cfg = ct_val[CT_OE_A+2];
         OE_TERM_D:     oe_cfg = ct_val[CT_OE_A+3];
         OE_ALWAYS_ON:  oe_cfg = 1'b1;
         default:       oe_cfg = 1'b0;
      endcase
   end

   wire oe_final = oe_cfg & has_pin & ~pin_is_in & ~gts_sync;
   wire buried   = has_pin & ~pin_is_in & (oe_sel == OE_ALWAYS_OFF);

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pin_out_reg  <= 1'b0;
         pin_oe_reg   <= 1'b0;
         pulldown_reg <= 1'b0;
         mc_fb_reg    <= 1'b0;
         pin_fb_reg   <= 1'b0;
      end
      else
      begin
         pin_out_reg  <= mc_out;
         pin_oe_reg   <= oe_final;
         pulldown_reg <= buried;
         mc_fb_reg    <= mc_out;
         pin_fb_reg   <= has_pin & pin_sync;
      end
   end

   assign pin_out            = pin_out_reg;
   assign pin_oe             = pin_oe_reg;
   assign pin_pulldown       = pulldown_reg;
   assign macrocell_feedback = mc_fb_reg;
   assign pin_feedback       = pin_fb_reg;

   // ------------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------------
   // out-of-range indices never reach the array read below
   wire [LIT_W-1:0] sel_mask = term_mask_reg[term_addr ? term_idx : '0];

   wire [DATA_W-1:0] status_word = {
      {(DATA_W-ST_GR-1){1'b0}}, gr_active, ct_val,
      pulldown_reg, pin_oe_reg, pin_fb_reg, mc_fb_reg, mc_reg};

   always_comb
   begin
      rd_next = '0;
      if (term_addr && word_sel == WORD_LO)
         rd_next = sel_mask[31:0];
      else if (term_addr && word_sel == WORD_MID)
         rd_next = sel_mask[63:32];
      else if (term_addr && word_sel == WORD_HI)
         rd_next = {{(DATA_W-HI_W){1'b0}}, sel_mask[LIT_W-1:64]};
      else if (reg_addr == ADDR_CFG)
         rd_next = {{(DATA_W-CFG_USED_W){1'b0}}, cfg_reg};
      else if (reg_addr == ADDR_PLA_SEL)
         rd_next = pla_sel_reg;
      else if (reg_addr == ADDR_CT_KIND)
         rd_next = {{(DATA_W-N_CT){1'b0}}, ct_kind_reg};
      else if (reg_addr == ADDR_STATUS)
         rd_next = status_word;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rd_data_reg <= '0;
      else
         rd_data_reg <= reg_rd ? rd_next : '0;
   end

   assign reg_rd_data = rd_data_reg;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   wire no_force = ~force_on;

   a_gts_outputs_off : assert property (gts_sync |=> !pin_oe)
      else $error("output enabled under global tristate");

   a_global_reset_zero : assert property (gr_active |=> !mc_reg)
      else $error("global reset did not clear register");

   a_gr_over_preset : assert property (
      gr_active && ar_active && ar_preset && mode != MODE_COMB
      |=> !macrocell_feedback)
      else $error("preset beat global reset");

   a_preset_immediate : assert property (
      no_force ##1 (ar_active && ar_preset && !gr_active
      && mode != MODE_COMB) |=> macrocell_feedback)
      else $error("preset not immediate");

   a_reset_term : assert property (
      ar_active && !ar_preset && !gr_active && mode != MODE_COMB
      |=> !macrocell_feedback && !mc_reg)
      else $error("reset term did not clear");

   a_ar_disabled : assert property (
      !ar_en && !gr_active && !clk_edge |=> $stable(mc_reg))
      else $error("disabled term changed register");

   a_d_capture : assert property (
      mode == MODE_D && clk_edge && no_force |=> mc_reg == $past(logic_in))
      else $error("d register missed data");

   a_t_toggle : assert property (
      mode == MODE_T && clk_edge && no_force
      |=> mc_reg == ($past(mc_reg) ^ $past(logic_in)))
      else $error("t register wrong");

   a_fall_edge : assert property (
      mode == MODE_D && clk_sel == CLK_GLOBAL_A && falling && no_force
      && gclk_prev_reg[0] && !gclk_a |=> mc_reg == $past(logic_in))
      else $error("falling edge missed");

   a_async_clock : assert property (
      mode == MODE_T && clk_sel == CLK_ASYNC_A && no_force && arise_a
      |=> mc_reg == ($past(mc_reg) ^ $past(logic_in)))
      else $error("async clock term missed");

   a_comb_bypass : assert property (
      mode == MODE_COMB |=> macrocell_feedback == $past(logic_in))
      else $error("bypass wrong");

   a_input_pin_oe : assert property (pin_is_in |=> !pin_oe)
      else $error("input pin driven");

   a_oe_term_c : assert property (
      oe_sel == OE_TERM_C && has_pin && !pin_is_in && !gts_sync
      |=> pin_oe == $past(ct_val[CT_OE_A+2]))
      else $error("oe term c not followed");

   a_fixed_oe : assert property (
      oe_sel == OE_ALWAYS_ON && has_pin && !pin_is_in && !gts_sync
      |=> pin_oe [*1])
      else $error("always-on buffer off");

   a_pulldown_on : assert property (
      has_pin && !pin_is_in && oe_sel == OE_ALWAYS_OFF |=> pin_pulldown)
      else $error("pull-down missing");

   a_buried_fb : assert property (!has_pin |=> !pin_feedback)
      else $error("pin feedback on buried cell");

   a_pin_fb : assert property (
      has_pin |=> pin_feedback == $past(pin_sync))
      else $error("pin feedback wrong");

   c_toggle : cover property (mode == MODE_T && clk_edge ##1 mc_reg);
   c_preset : cover property (ar_active && ar_preset ##1 macrocell_feedback);
   c_gts    : cover property (pin_oe ##1 gts_sync ##1 !pin_oe);
   c_pin_in : cover property (pin_is_in && pin_sync ##1 pin_feedback);

endmodule

// ===== testbench/clm_board.sv
// Purpose: board around the macrocell: global clock sources and pad
// Assumes: the bench asks for one pulse per clock at a time
// Notes:   a floating pad toggles every cycle, never holds a stale level

`timescale 1ns/100ps

module clm_board
(
   // clock and requests
   input  wire logic       clk,
   input  wire logic [1:0] pulse_req,
   input  wire logic       ext_drive,
   input  wire logic       ext_val,
   // pad side of the macrocell
   input  wire logic       pin_out,
   input  wire logic       pin_oe,
   input  wire logic       pin_pulldown,
   output logic            pin_in,
   output logic [1:0]      gclk
);
   logic [4:0] cnt_reg [2] = '{5'h0, 5'h0};
   logic       flip_reg = 1'b0;

   // clocks stand low; a request gives one 16-cycle high pulse
   always_ff @(posedge clk)
   begin
      flip_reg <= ~flip_reg;
      for (int i = 0; i < 2; i++)
         cnt_reg[i] <= pulse_req[i] ? 5'h10 : cnt_reg[i] - 5'(cnt_reg[i] != 5'h0);
   end
   assign gclk[0] = cnt_reg[0] != 5'h0;
   assign gclk[1] = cnt_reg[1] != 5'h0;
   assign pin_in = pin_oe ? pin_out : ext_drive ? ext_val : pin_pulldown ? 1'b0 : flip_reg;
endmodule

// ===== testbench/configurable_logic_macrocell_test.sv
// Purpose: self-checking bench for the macrocell
// Assumes: read data stands one cycle after the read strobe
// Notes:   reads queue their expectation, a monitor pops and compares

`timescale 1ns/100ps

module configurable_logic_macrocell_test
   import clm_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wd = '0;
   logic [DATA_W-1:0] rdata;
   logic              wr_s = 1'b0;
   logic              rd_s = 1'b0;
   logic              rd_seen = 1'b0;
   logic              grn = 1'b1;
   logic              gts = 1'b0;
   logic [N_SIG-1:0]  li = '0;
   logic [1:0]        preq = '0;
   logic [1:0]        gclk;
   logic              xdrv = 1'b0;
   logic              xval = 1'b0;
   logic              pin_in, pin_out, pin_oe, pd, mfb, pfb;
   logic [31:0]       exp_q[$], msk_q[$];
   logic [31:0]       e, m;
   logic              q = 1'b1;
   logic              d;
   logic [31:0]       cfg_t [4] = '{32'h2461, 32'h2421, 32'h24e1, 32'h2401};
   logic [N_SIG-1:0]  li_t [4] = '{36'h2, 36'h2, 36'h40, 36'h42};
   logic [3:0]        ex_t = 4'b1101;
   int                n_fail = 0;
   int                checks_done = 0;
   int                cycles = 0;
   int                seed = 32'h28e9fa8a;

   always #2.5 clk = ~clk;

   clm_macrocell u_clm_macrocell (
      .clk(clk), .reset(reset), .reg_addr(addr), .reg_wr_data(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rd_data(rdata), .global_clock_a(gclk[0]),
      .global_clock_b(gclk[1]), .global_reset_n(grn), .global_tristate(gts),
      .local_interconnect_in(li), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pulldown(pd), .macrocell_feedback(mfb), .pin_feedback(pfb));

   clm_board u_clm_board (
      .clk(clk), .pulse_req(preq), .ext_drive(xdrv), .ext_val(xval), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pulldown(pd), .pin_in(pin_in), .gclk(gclk));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wd   <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      @(posedge clk);
      exp_q.push_back(ex);
      msk_q.push_back(mk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
   endtask

   task automatic pulse(input int b);
      @(posedge clk);
      preq <= 2'(1 << b);
      @(posedge clk);
      preq <= 2'h0;
   endtask

   task automatic print_verdict();
      $display("checks %0d, errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ------------------------------------------------------------
   // monitor and watchdog
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rd_seen)
      begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         checks_done++;
         if ((rdata & m) !== e)
         begin
            n_fail++;
            $display("ERROR at %0t: got %h, expected %h", $time, rdata & m, e);
         end
         // pins must agree with the status word once settled
         if (addr == ADDR_STATUS)
         begin
            checks_done++;
            if (({pd, pin_oe, pfb, mfb} & m[4:1]) !== e[4:1])
            begin
               n_fail++;
               $display("ERROR at %0t: pins %h, expected %h", $time,
                        {pd, pin_oe, pfb, mfb} & m[4:1], e[4:1]);
            end
         end
      end
      rd_seen <= rd_s;
      cycles++;
      if (cycles == 4000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd_reg(ADDR_CFG, 32'(CFG_RESET), 32'h7fff);
      rd_reg(ADDR_STATUS, 32'h0, 32'h1f);
      rd_reg(8'hc4, 32'h0, '1);
      rd_reg(8'h03, 32'h0, '1);
      wr_reg(8'h00, 32'h1);
      wr_reg(8'h10, 32'h4);
      wr_reg(ADDR_PLA_SEL, 32'h1);
      rd_reg(8'h00, 32'h1, '1);
      for (int k = 0; k < 3; k++)
      begin
         wr_reg(ADDR_CFG, k == 0 ? 32'h2400 : k == 1 ? 32'h2c00 : 32'h3400);
         repeat (4)
         begin
            li <= 36'({$random(seed), $random(seed)});
            cyc(8);
            d = k == 1 ? li[0] ^ li[2] : (li[0] | li[2]) ^ (k == 2);
            rd_reg(ADDR_STATUS, {28'h0, 1'b1, d, d, 1'b0}, 32'he);
         end
      end
      gts <= 1'b1;
      cyc(8);
      rd_reg(ADDR_STATUS, 32'h0, 32'h18);
      gts <= 1'b0;
      // oe terms a and c are sums, b and d products
      wr_reg(ADDR_CT_KIND, 32'h14);
      for (int s = 0; s < 4; s++)
         wr_reg(8'h98 + 8'(4 * s), 32'h88 << s);
      for (int s = 0; s < 6; s++)
      begin
         wr_reg(ADDR_CFG, 32'h2000 | 32'(s << 8));
         li <= 36'({$random(seed), $random(seed)});
         cyc(8);
         d = s > 3 ? s == 4 : s % 2 ? li[3 + s] & li[7 + s] : li[3 + s] | li[7 + s];
         rd_reg(ADDR_STATUS, {27'h0, s == 5, d, 3'h0}, 32'h18);
      end
      wr_reg(8'h90, 32'h2);
      wr_reg(8'h94, 32'h40);
      for (int i = 0; i < 4; i++)
      begin
         // terms idle during the write so each force starts from none
         li <= '0;
         wr_reg(ADDR_CFG, cfg_t[i]);
         li <= li_t[i];
         cyc(3);
         rd_reg(ADDR_STATUS, 32'(ex_t[i]), 32'h1);
      end
      wr_reg(ADDR_CFG, 32'h2461);
      li <= 36'h2;
      grn <= 1'b0;
      cyc(6);
      rd_reg(ADDR_STATUS, 32'h2000, 32'h2001);
      grn <= 1'b1;
      cyc(6);
      rd_reg(ADDR_STATUS, 32'h1, 32'h2001);
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(ADDR_CFG, 32'h2401 | 32'((i & 1) << 2 | (i & 2) << 3));
         li <= 36'(!q);
         pulse(1 - i % 2);
         cyc(20);
         rd_reg(ADDR_STATUS, 32'(q), 32'h1);
         pulse(i % 2);
         cyc(10);
         rd_reg(ADDR_STATUS, 32'(i > 1 ? q : !q), 32'h1);
         cyc(12);
         q = !q;
         rd_reg(ADDR_STATUS, 32'(q), 32'h1);
      end
      wr_reg(8'ha8, 32'h20);
      wr_reg(8'hac, 32'h20);
      for (int j = 0; j < 4; j++)
      begin
         // odd passes take their clock from the second async term
         wr_reg(ADDR_CFG, 32'h240a | 32'((j & 1) << 2));
         li <= j < 3 ? 36'h21 : 36'h20;
         cyc(4);
         li <= j < 3 ? 36'h1 : 36'h0;
         cyc(4);
         q = q ^ (j < 3);
         rd_reg(ADDR_STATUS, 32'(q), 32'h1);
      end
      wr_reg(ADDR_CFG, 32'h6400);
      xdrv <= 1'b1;
      repeat (4)
      begin
         xval <= 1'($random(seed));
         li <= 36'($random(seed));
         cyc(8);
         d = li[0] | li[2];
         rd_reg(ADDR_STATUS, {28'h0, 1'b0, xval, d, 1'b0}, 32'he);
      end
      xdrv <= 1'b0;
      wr_reg(ADDR_CFG, 32'h0400);
      cyc(8);
      rd_reg(ADDR_STATUS, 32'h0, 32'h1c);
      cyc(3);
      print_verdict();
   end
endmodule
